// ==== common/scs_link_if.sv ====
`timescale 1ns/1ps
interface scs_link_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   wire  scl;
   wire  sda;

   // Open-drain lines with pull-up
   assign scl = !(host_scl_oe && !host_scl_o);
   assign sda = !((host_sda_oe && !host_sda_o) ||
                  (dev_sda_oe && !dev_sda_o));

   modport host (
      output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
      input  scl, sda
   );

   modport dev (
      output dev_sda_o, dev_sda_oe,
      input  scl, sda
   );
endinterface : scs_link_if

// ==== common/scs_pkg.sv ====
package scs_pkg;

   // Core clock
   localparam int CLK_PERIOD_NS = 8;

   // Link timing
   localparam int LINK_RATE_KBPS = 400;
   localparam int T_LOW_NS       = 1300;
   localparam int T_HIGH_NS      = 600;
   // Four slots per bit, two low and two high
   localparam int SLOT_NS        = T_LOW_NS / 2;
   localparam int SLOT_CYC       =
      (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Slave identity
   localparam logic [6:0] SLV_ADDR_BASE = 7'h60;
   localparam int         ID_SEL_W      = 3;

   // Device register bank
   localparam int          NREG       = 16;
   localparam logic [15:0] IMPL_MASK  = 16'hf0ef;
   localparam logic [7:0]  REG_RST    = 8'h00;
   localparam logic [7:0]  RD_UNIMPL  = 8'hff;

   // Host registers, byte offsets
   localparam logic [4:0] HOST_CTRL_OFF   = 5'h00;
   localparam logic [4:0] HOST_SLAVE_OFF  = 5'h04;
   localparam logic [4:0] HOST_SUB_OFF    = 5'h08;
   localparam logic [4:0] HOST_WDATA_OFF  = 5'h0c;
   localparam logic [4:0] HOST_STATUS_OFF = 5'h10;

   // Control fields
   localparam int CTRL_GO_BIT     = 0;
   localparam int CTRL_READ_BIT   = 1;
   localparam int CTRL_NODATA_BIT = 2;

   // Status fields
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_NACK_BIT  = 1;
   localparam int STAT_RDATA_LSB = 8;

endpackage : scs_pkg

// ==== src/scs_device.sv ====
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Select strap high enables slave operation
// - Bytes move most significant bit first
// - First byte: 7-bit address, direction LSB
// - Data changes only while clock low
// - Write: subaddress byte, then register data
// - Read uses subaddress kept from writes
// - Read returns register at stored subaddress
// - Subaddress increments after each data byte
// - Master rewrites subaddress after multi-byte
// - Multi-ID: select pins pick eight addresses
// - Multi-ID low: only C0/C1 answered
// - Unimplemented subaddress writes change nothing
// - Unimplemented subaddress reads undefined
module scs_device
   import scs_pkg::*;
#(
   parameter int          NUM_REGS = NREG,
   parameter logic [15:0] IMPL     = IMPL_MASK
) (
   // Clock and reset
   input  wire logic                  CLOCK_I,
   input  wire logic                  RST_N_I,
   // Link
   scs_link_if.dev                    LINK,
   // Straps
   input  wire logic                  SERIAL_PORT_SELECT_I,
   input  wire logic                  MULTI_ID_ENABLE_I,
   input  wire logic [ID_SEL_W-1:0]   SLAVE_ID_SEL_I,
   // Register bank view
   output logic      [NUM_REGS*8-1:0] REGS_O,
   output logic                       REG_WR_O,
   output logic      [7:0]            REG_WADDR_O,
   output logic      [7:0]            REG_WDATA_O,
   output logic                       BUSY_O
);

   localparam int IW = $clog2(NUM_REGS);
   localparam int SW = ID_SEL_W + 4;

   typedef enum logic [2:0] {
      D_IDLE,
      D_RX,
      D_RX_ACK,
      D_TX,
      D_TX_ACK
   } scs_dstate_e;

   scs_dstate_e state_q;
   logic [SW-1:0]    pins_s;
   logic             scl_s;
   logic             sda_s;
   logic             en_s;
   logic             multi_id_s;
   logic [ID_SEL_W-1:0] id_sel_s;
   logic             scl_p_q;
   logic             sda_p_q;
   logic [7:0]       shift_q;
   logic [3:0]       bit_q;
   logic [1:0]       idx_q;
   logic             rw_q;
   logic [7:0]       ptr_q;
   logic             oe_q;
   logic             acked_q;
   logic             wr_q;
   logic [7:0]       waddr_q;
   logic [7:0]       wdata_q;
   logic             busy_q;
   logic [7:0]       regs_q [NUM_REGS];

   // All pins cross into the core clock
   scs_sync #(
      .W       (SW),
      .RST_VAL ({2'b11, {(SW-2){1'b0}}})
   ) u_sync (
      .CLOCK_I (CLOCK_I),
      .RST_N_I (RST_N_I),
      .D_I     ({LINK.scl, LINK.sda, SERIAL_PORT_SELECT_I,
                 MULTI_ID_ENABLE_I, SLAVE_ID_SEL_I}),
      .Q_O     (pins_s)
   );

   assign scl_s      = pins_s[SW-1];
   assign sda_s      = pins_s[SW-2];
   assign en_s       = pins_s[SW-3];
   assign multi_id_s = pins_s[SW-4];
   assign id_sel_s   = pins_s[ID_SEL_W-1:0];

   // Previous line levels for edge finding
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // Line events
   wire scl_rise = scl_s & ~scl_p_q;
   wire scl_fall = ~scl_s & scl_p_q;
   wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // Own address from straps
   wire [6:0] my_addr = multi_id_s
      ? SLV_ADDR_BASE + {3'b000, id_sel_s, 1'b0}
      : SLV_ADDR_BASE;
   wire addr_hit = (shift_q[7:1] == my_addr);

   // Stored subaddress decode
   wire [IW-1:0] ptr_idx  = ptr_q[IW-1:0];
   wire          in_range = ((ptr_q >> IW) == 8'h00);
   wire          impl_hit = in_range & IMPL[ptr_idx];
   wire [7:0]    rd_byte  = impl_hit ? regs_q[ptr_idx]
                                     : RD_UNIMPL;

   // Byte complete in receive
   wire byte_done = (state_q == D_RX) & scl_fall & (bit_q == 4'd8);
   wire wr_now    = byte_done & (idx_q == 2'd2);
   wire wr_hit    = wr_now & impl_hit;

   // Transaction sequencer
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q <= D_IDLE;
         shift_q <= 8'h00;
         bit_q   <= 4'h0;
         idx_q   <= 2'd0;
         rw_q    <= 1'b0;
         ptr_q   <= 8'h00;
         oe_q    <= 1'b0;
         acked_q <= 1'b0;
      end else if (!en_s) begin
         state_q <= D_IDLE;
         oe_q    <= 1'b0;
      end else if (start_ev) begin
         state_q <= D_RX;
         bit_q   <= 4'h0;
         idx_q   <= 2'd0;
         oe_q    <= 1'b0;
      end else if (stop_ev) begin
         state_q <= D_IDLE;
         oe_q    <= 1'b0;
      end else begin
         unique case (state_q)
            D_IDLE: begin
               oe_q <= 1'b0;
            end
            D_RX: begin
               if (scl_rise && bit_q != 4'd8) begin
                  shift_q <= {shift_q[6:0], sda_s};
                  bit_q   <= bit_q + 4'h1;
               end
               if (byte_done) begin
                  if (idx_q == 2'd0) begin
                     if (addr_hit) begin
                        rw_q    <= shift_q[0];
                        oe_q    <= 1'b1;
                        state_q <= D_RX_ACK;
                        idx_q   <= 2'd1;
                     end else begin
                        state_q <= D_IDLE;
                     end
                  end else begin
                     oe_q    <= 1'b1;
                     state_q <= D_RX_ACK;
                     idx_q   <= 2'd2;
                     if (idx_q == 2'd1) begin
                        ptr_q <= shift_q;
                     end else begin
                        ptr_q <= ptr_q + 8'h01;
                     end
                  end
               end
            end
            D_RX_ACK: begin
               if (scl_fall) begin
                  bit_q <= 4'h0;
                  if (rw_q) begin
                     state_q <= D_TX;
                     shift_q <= rd_byte;
                     oe_q    <= ~rd_byte[7];
                  end else begin
                     state_q <= D_RX;
                     oe_q    <= 1'b0;
                  end
               end
            end
            D_TX: begin
               if (scl_fall) begin
                  if (bit_q == 4'd7) begin
                     oe_q    <= 1'b0;
                     state_q <= D_TX_ACK;
                  end else begin
                     bit_q   <= bit_q + 4'h1;
                     shift_q <= {shift_q[6:0], 1'b0};
                     oe_q    <= ~shift_q[6];
                  end
               end
            end
            D_TX_ACK: begin
               if (scl_rise) begin
                  ptr_q   <= ptr_q + 8'h01;
                  acked_q <= ~sda_s;
               end
               if (scl_fall) begin
                  bit_q <= 4'h0;
                  if (acked_q) begin
                     state_q <= D_TX;
                     shift_q <= rd_byte;
                     oe_q    <= ~rd_byte[7];
                  end else begin
                     state_q <= D_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Register bank, one write port per entry
   for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
         if (!RST_N_I) begin
            regs_q[i] <= REG_RST;
         end else if (wr_hit && ptr_idx == IW'(i)) begin
            regs_q[i] <= shift_q;
         end
      end
      assign REGS_O[i*8 +: 8] = regs_q[i];
   end

   // Write notification to the user side
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wr_q    <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= 8'h00;
         busy_q  <= 1'b0;
      end else begin
         wr_q   <= wr_hit;
         busy_q <= (state_q != D_IDLE);
         if (wr_hit) begin
            waddr_q <= ptr_q;
            wdata_q <= shift_q;
         end
      end
   end

   // Outputs
   assign LINK.dev_sda_o  = 1'b0;
   assign LINK.dev_sda_oe = oe_q;
   assign REG_WR_O        = wr_q;
   assign REG_WADDR_O     = waddr_q;
   assign REG_WDATA_O     = wdata_q;
   assign BUSY_O          = busy_q;

endmodule : scs_device

// ==== src/scs_host.sv ====
`timescale 1ns/1ps
module scs_host
   import scs_pkg::*;
#(
   parameter int SLOT = SLOT_CYC
) (
   // Clock and reset
   input  wire logic        CLOCK_I,
   input  wire logic        RST_N_I,
   // Wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [4:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // Link
   scs_link_if.host         LINK
);

   typedef enum logic [1:0] {
      H_IDLE,
      H_START,
      H_BIT,
      H_STOP
   } scs_hstate_e;

   scs_hstate_e state_q;
   logic [15:0] div_q;
   logic [1:0]  ph_q;
   logic [3:0]  bit_q;
   logic [1:0]  byt_q;
   logic [1:0]  last_q;
   logic [6:0]  slave_q;
   logic [7:0]  sub_q;
   logic [7:0]  wdata_q;
   logic [7:0]  rdata_q;
   logic        rd_q;
   logic        nack_q;
   logic        scl_low_q;
   logic        sda_low_q;
   logic        ack_q;
   logic [31:0] dat_q;
   logic        sda_s;

   // Data line into the core clock
   scs_sync #(
      .W       (1),
      .RST_VAL (1'b1)
   ) u_sync (
      .CLOCK_I (CLOCK_I),
      .RST_N_I (RST_N_I),
      .D_I     (LINK.sda),
      .Q_O     (sda_s)
   );

   // Bus decode
   wire req    = WB_CYC_I & WB_STB_I & ~ack_q;
   wire acc    = WB_CYC_I & WB_STB_I & ack_q;  // Ack edge, write lands
   wire wr_lo  = acc & WB_WE_I & WB_SEL_I[0];
   wire idle   = (state_q == H_IDLE);
   wire go     = wr_lo & (WB_ADR_I == HOST_CTRL_OFF) & idle
                 & WB_DAT_I[CTRL_GO_BIT];
   wire [31:0] rd_mux =
      (WB_ADR_I == HOST_STATUS_OFF) ?
         {16'h0000, rdata_q, 6'h00, nack_q, ~idle} :
      (WB_ADR_I == HOST_SLAVE_OFF) ? {25'h0, slave_q} :
      (WB_ADR_I == HOST_SUB_OFF)   ? {24'h0, sub_q} :
      (WB_ADR_I == HOST_WDATA_OFF) ? {24'h0, wdata_q} : 32'h0;

   // Byte being moved and its next bit
   wire       rx      = rd_q & (byt_q == 2'd1);
   wire [7:0] cur     = (byt_q == 2'd0) ? {slave_q, rd_q} :
                        (byt_q == 2'd1) ? sub_q : wdata_q;
   wire       out_bit = bit_q[3] | rx | cur[3'd7 - bit_q[2:0]];
   wire       tick    = (div_q == 16'(SLOT - 1));

   // Bus answer, one cycle after the request
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= req;
         dat_q <= rd_mux;
      end
   end

   // Parameter registers
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         slave_q <= SLV_ADDR_BASE;
         sub_q   <= 8'h00;
         wdata_q <= 8'h00;
      end else if (wr_lo && idle) begin
         if (WB_ADR_I == HOST_SLAVE_OFF) slave_q <= WB_DAT_I[6:0];
         if (WB_ADR_I == HOST_SUB_OFF)   sub_q   <= WB_DAT_I[7:0];
         if (WB_ADR_I == HOST_WDATA_OFF) wdata_q <= WB_DAT_I[7:0];
      end
   end

   // Bit engine, four slots per bit
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q   <= H_IDLE;
         div_q     <= 16'h0;
         ph_q      <= 2'd0;
         bit_q     <= 4'h0;
         byt_q     <= 2'd0;
         last_q    <= 2'd0;
         rd_q      <= 1'b0;
         nack_q    <= 1'b0;
         rdata_q   <= 8'h00;
         scl_low_q <= 1'b0;
         sda_low_q <= 1'b0;
      end else if (idle) begin
         if (go) begin
            state_q <= H_START;
            div_q   <= 16'h0;
            ph_q    <= 2'd0;
            bit_q   <= 4'h0;
            byt_q   <= 2'd0;
            nack_q  <= 1'b0;
            rd_q    <= WB_DAT_I[CTRL_READ_BIT];
            last_q  <= (WB_DAT_I[CTRL_READ_BIT] ||
                        WB_DAT_I[CTRL_NODATA_BIT]) ? 2'd1 : 2'd2;
         end
      end else begin
         div_q <= tick ? 16'h0 : div_q + 16'h1;
         if (tick) begin
            ph_q <= ph_q + 2'd1;
            unique case (state_q)
               H_START: begin
                  if (ph_q == 2'd0) sda_low_q <= 1'b1;
                  if (ph_q == 2'd3) begin
                     scl_low_q <= 1'b1;
                     state_q   <= H_BIT;
                  end
               end
               H_BIT: begin
                  if (ph_q == 2'd0) sda_low_q <= ~out_bit;
                  if (ph_q == 2'd1) scl_low_q <= 1'b0;
                  if (ph_q == 2'd3) begin
                     scl_low_q <= 1'b1;
                     if (!bit_q[3]) begin
                        bit_q <= bit_q + 4'h1;
                        if (rx) rdata_q <= {rdata_q[6:0], sda_s};
                     end else if (!rx && sda_s) begin
                        nack_q  <= 1'b1;
                        state_q <= H_STOP;
                     end else if (byt_q == last_q) begin
                        state_q <= H_STOP;
                     end else begin
                        byt_q <= byt_q + 2'd1;
                        bit_q <= 4'h0;
                     end
                  end
               end
               H_STOP: begin
                  if (ph_q == 2'd0) sda_low_q <= 1'b1;
                  if (ph_q == 2'd1) scl_low_q <= 1'b0;
                  if (ph_q == 2'd2) sda_low_q <= 1'b0;
                  if (ph_q == 2'd3) state_q   <= H_IDLE;
               end
            endcase
         end
      end
   end

   // Outputs
   assign WB_ACK_O         = ack_q;
   assign WB_DAT_O         = dat_q;
   assign LINK.host_scl_o  = 1'b0;
   assign LINK.host_scl_oe = scl_low_q;
   assign LINK.host_sda_o  = 1'b0;
   assign LINK.host_sda_oe = sda_low_q;

endmodule : scs_host

// ==== src/scs_sync.sv ====
`timescale 1ns/1ps
module scs_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         CLOCK_I,
   input  wire logic         RST_N_I,
   // Data
   input  wire logic [W-1:0] D_I,
   output logic      [W-1:0] Q_O
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // Two-stage synchroniser
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= D_I;
         sync_q <= meta_q;
      end
   end

   assign Q_O = sync_q;

endmodule : scs_sync

// ==== tb/scs_sva.sv ====
`timescale 1ns/1ps
module scs_sva (
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   // Link signals
   input wire logic host_scl_o,
   input wire logic host_scl_oe,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);

   // Drivers only ever pull low
   property p_od;
      host_scl_o == 1'b0 && host_sda_o == 1'b0 && dev_sda_o == 1'b0;
   endproperty
   a_od: assert property (p_od)
      else $error("link output driven high");
   // Lines released just after reset
   property p_rst;
      $rose(RST_N_I) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe;
   endproperty
   a_rst: assert property (p_rst)
      else $error("line held after reset");
   // Start made by the host alone
   property p_start;
      scl && $fell(sda) |-> host_sda_oe && !dev_sda_oe;
   endproperty
   a_start: assert property (p_start)
      else $error("start not made by host");
   // Device stays off the line after a stop
   property p_stop;
      scl && $rose(sda) |=> !dev_sda_oe [*8];
   endproperty
   a_stop: assert property (p_stop)
      else $error("device drives after stop");
   // Device moves data only while clock low
   property p_dev_chg;
      $changed(dev_sda_oe) |-> !scl;
   endproperty
   a_dev_chg: assert property (p_dev_chg)
      else $error("device data changed with clock high");
   // Device data steady across the high phase
   property p_dev_stable;
      $rose(scl) |-> $stable(dev_sda_oe) [*7];
   endproperty
   a_dev_stable: assert property (p_dev_stable)
      else $error("device data moved in high phase");
   // High phase lasts two slots, SLOT of four or more
   property p_scl_hi;
      $rose(scl) |-> scl [*7];
   endproperty
   a_scl_hi: assert property (p_scl_hi)
      else $error("clock high phase too short");
   // Low phase lasts at least one slot
   property p_scl_lo;
      $fell(scl) |-> !scl [*3];
   endproperty
   a_scl_lo: assert property (p_scl_lo)
      else $error("clock low phase too short");
endmodule : scs_sva

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import scs_pkg::*;
   logic         clk;
   logic         rst_n;
   logic         cyc, stb, we, ack;
   logic [4:0]   adr;
   logic [31:0]  dat_w, dat_r, q;
   logic         port_sel, multi, reg_wr, busy;
   logic [2:0]   id_sel;
   logic [127:0] regs, exp_regs;
   logic [7:0]   reg_waddr, reg_wdata, sniff_q, first_byte;
   logic         scl_q, sda_q;
   int           nbits = 100;
   int           n_wr = 0;
   int           n_fail = 0;
   int           total_checks = 0;

   scs_link_if scs_link_if_inst ();
   scs_host #(.SLOT(4)) scs_host_inst (.CLOCK_I(clk), .RST_N_I(rst_n),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(4'hf), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
      .WB_ACK_O(ack), .LINK(scs_link_if_inst));
   scs_device scs_device_inst (.CLOCK_I(clk), .RST_N_I(rst_n),
      .LINK(scs_link_if_inst), .SERIAL_PORT_SELECT_I(port_sel),
      .MULTI_ID_ENABLE_I(multi), .SLAVE_ID_SEL_I(id_sel), .REGS_O(regs),
      .REG_WR_O(reg_wr), .REG_WADDR_O(reg_waddr),
      .REG_WDATA_O(reg_wdata), .BUSY_O(busy));
   scs_sva scs_sva_inst (.CLOCK_I(clk), .RST_N_I(rst_n),
      .host_scl_o(scs_link_if_inst.host_scl_o),
      .host_scl_oe(scs_link_if_inst.host_scl_oe),
      .host_sda_o(scs_link_if_inst.host_sda_o),
      .host_sda_oe(scs_link_if_inst.host_sda_oe),
      .dev_sda_o(scs_link_if_inst.dev_sda_o),
      .dev_sda_oe(scs_link_if_inst.dev_sda_oe),
      .scl(scs_link_if_inst.scl), .sda(scs_link_if_inst.sda));

   // Core clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Sniffer: first byte after each start, shifted on clock rise
   always @(posedge clk) begin
      scl_q <= scs_link_if_inst.scl;
      sda_q <= scs_link_if_inst.sda;
      if (reg_wr === 1'b1) n_wr <= n_wr + 1;
      if (scs_link_if_inst.scl && sda_q === 1'b1 && !scs_link_if_inst.sda)
         nbits <= 0;
      else if (scs_link_if_inst.scl && scl_q === 1'b0) begin
         sniff_q <= {sniff_q[6:0], scs_link_if_inst.sda};
         nbits <= nbits + 1;
         if (nbits == 7) first_byte <= {sniff_q[6:0], scs_link_if_inst.sda};
      end
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [127:0] e,
                      input logic [127:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic test_done(input string name);
      $display("test %s done", name);
   endtask : test_done

   // One classic Wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      r = dat_r;
      chk("wishbone latency", 128'h2, 128'(n));
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   // Program one link transaction and wait for idle status
   task automatic xact(input logic [6:0] s, input logic [7:0] sub,
                       input logic [7:0] d, input logic [31:0] ctl,
                       output logic [31:0] st);
      logic [31:0] r;
      wb(1'b1, HOST_SLAVE_OFF, {25'h0, s}, r);
      wb(1'b1, HOST_SUB_OFF, {24'h0, sub}, r);
      wb(1'b1, HOST_WDATA_OFF, {24'h0, d}, r);
      wb(1'b1, HOST_CTRL_OFF, ctl, r);
      do begin
         wb(1'b0, HOST_STATUS_OFF, 32'h0, st);
      end while (st[STAT_BUSY_BIT] !== 1'b0);
   endtask : xact

   task automatic wr(input logic [6:0] s, input logic [7:0] sub,
                     input logic [7:0] d, input logic nk);
      logic [31:0] st;
      xact(s, sub, d, 32'h1, st);
      if (!nk && IMPL_MASK[sub[3:0]]) exp_regs[sub[3:0]*8 +: 8] = d;
      chk("nack", 128'(nk), 128'(st[STAT_NACK_BIT]));
      chk("registers", exp_regs, regs);
      chk("address byte", 128'({s, 1'b0}), 128'(first_byte));
   endtask : wr

   task automatic rd(input logic [6:0] s, input logic [7:0] e);
      logic [31:0] st;
      xact(s, 8'h00, 8'h00, 32'h3, st);
      chk("read data", 128'(e), 128'(st[15:8]));
      chk("address byte", 128'({s, 1'b1}), 128'(first_byte));
   endtask : rd

   // Watchdog
   initial begin
      #(CLK_PERIOD_NS * 50000);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      logic [31:0] st;
      {cyc, stb, we, adr, dat_w} <= '0;
      port_sel <= 1'b1;
      multi <= 1'b0;
      id_sel <= 3'h5;
      exp_regs = '0;
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      wb(1'b0, HOST_SLAVE_OFF, 32'h0, q);
      chk("slave reset", 128'h60, 128'(q));
      wb(1'b0, 5'h14, 32'h0, q);
      chk("unmapped read", 128'h0, 128'(q));
      chk("registers reset", 128'h0, regs);
      test_done("reset");
      wr(7'h60, 8'h05, 8'ha5, 1'b0);
      chk("write subaddress", 128'h5, 128'(reg_waddr));
      chk("write data", 128'ha5, 128'(reg_wdata));
      wr(7'h62, 8'h06, 8'h11, 1'b1);
      wr(7'h60, 8'h04, 8'h77, 1'b0);
      wr(7'h60, 8'h0a, 8'h77, 1'b0);
      chk("write pulses", 128'h1, 128'(n_wr));
      test_done("single id");
      multi <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         id_sel <= i[2:0];
         wr(7'h60 + 7'(2 * i), 8'h0f, 8'(8'h30 + i), 1'b0);
         wr(7'h60 + 7'(2 * ((i + 1) % 8)), 8'h0e, 8'h5a, 1'b1);
      end
      test_done("multi id");
      xact(7'h6e, 8'h05, 8'h00, 32'h5, st);
      rd(7'h6e, 8'ha5);
      rd(7'h6e, 8'h00);
      multi <= 1'b0;
      wr(7'h6e, 8'h0e, 8'h11, 1'b1);
      xact(7'h60, 8'h0f, 8'h00, 32'h5, st);
      rd(7'h60, 8'h37);
      test_done("read pointer");
      port_sel <= 1'b0;
      wr(7'h60, 8'h01, 8'h42, 1'b1);
      port_sel <= 1'b1;
      wr(7'h60, 8'h01, 8'h42, 1'b0);
      repeat (20) @(posedge clk);
      chk("device busy", 128'h0, 128'(busy));
      test_done("port select");
      tally_and_finish();
   end
endmodule : testbench
